// *** include/mrzd_pkg.sv ***
// Package: mode register zero field layout, encodings and timing constants
package mrzd_pkg;

    localparam int MODE_W        = 19;
    localparam int COL_W         = 10;
    localparam int BEAT_W        = 3;
    localparam int BANK_W        = 3;

    // Field positions
    localparam int BLEN_LO       = 0;
    localparam int BORD_BIT      = 3;
    localparam int LAT_LO        = 4;
    localparam int LAT_EXT_BIT   = 2;
    localparam int DLLRST_BIT    = 8;
    localparam int WREC_LO       = 9;
    localparam int PDDLL_BIT     = 12;
    localparam int OTF_ADDR_BIT  = 12;

    localparam logic [MODE_W-1:0] RSVD_MASK = 19'h4e080;
    localparam logic [MODE_W-1:0] MODE_RST  = 19'h00000;
    localparam logic [BANK_W-1:0] MODE0_BANK = 3'h0;

    localparam logic [1:0] BLEN_FIX8 = 2'h0;
    localparam logic [1:0] BLEN_OTF  = 2'h1;
    localparam logic [1:0] BLEN_FIX4 = 2'h2;

    localparam int BEATS_FULL    = 8;
    localparam int BEATS_CHOP    = 4;

    // Time the DLL takes to relock after a resync
    localparam int DLL_LOCK_CYC  = 512;

    typedef enum logic [1:0] {
        MRZD_CMD_NONE,
        MRZD_CMD_MODE,
        MRZD_CMD_READ,
        MRZD_CMD_WRITE
    } mrzd_cmd_t;

    typedef struct packed {
        mrzd_cmd_t         cmd;
        logic [BANK_W-1:0] bank;
        logic [MODE_W-1:0] addr;
    } mrzd_req_t;

    typedef struct packed {
        logic       chop;
        logic       interleave;
        logic [3:0] read_lat;
        logic [4:0] write_rec;
        logic       pd_dll_on;
        logic       reserved_err;
    } mrzd_cfg_t;

endpackage : mrzd_pkg

// *** core/mrzd_beat_order.sv ***
// Beat index generator: read and write column ordering within a burst
`timescale 1ns/1ps
`default_nettype none
module mrzd_beat_order
    import mrzd_pkg::*;
(
    input  wire logic [BEAT_W-1:0] start_col,
    input  wire logic [BEAT_W-1:0] beat,
    input  wire logic              interleave,
    input  wire logic              is_write,
    input  wire logic              chop,
    output logic      [BEAT_W-1:0] col
);

    logic [BEAT_W-1:0] st;

    always_comb
    begin
        st = start_col;
        // Writes see only nibble select on a chop, nothing on a full burst
        if (is_write)
        begin
            st = chop ? {start_col[2], 2'h0} : 3'h0;
        end
        if (interleave)
        begin
            col = st ^ beat;
        end
        else
        begin
            // Wrap modulo four inside a nibble, start nibble first
            col = {st[2] ^ beat[2], 2'(st[1:0] + beat[1:0])};
        end
    end

endmodule : mrzd_beat_order
`default_nettype wire

// *** core/mrzd_mode_zero.sv ***
// Mode register zero: load, decode, DLL resync and burst sequencing
`timescale 1ns/1ps
`default_nettype none
module mrzd_mode_zero
    import mrzd_pkg::*;
#(
    parameter int LOCK_CYC = DLL_LOCK_CYC
)
(
    input  wire logic              MCLK,
    input  wire logic              RST,
    input  wire mrzd_req_t         REQ,
    input  wire logic              PRECHARGE_PD,
    input  wire logic              ACTIVE_PD,
    output mrzd_cfg_t              CFG,
    output logic [MODE_W-1:0]      MODE_READBACK,
    output logic                   DLL_RESYNC,
    output logic                   DLL_LOCKED,
    output logic                   DLL_RUN,
    output logic                   SLOW_EXIT,
    output logic                   DATA_OE,
    output logic                   STROBE_OE,
    output logic                   WRITE_EN,
    output logic [BEAT_W-1:0]      BEAT_COL,
    output logic                   BURST_BUSY
);

    typedef enum logic [1:0] {
        MRZD_IDLE,
        MRZD_WAIT,
        MRZD_BEATS
    } mrzd_state_t;

    logic [MODE_W-1:0] mode_q, mode_d;
    logic              rsvd_q, rsvd_d;
    logic              resync_q, resync_d;
    logic [9:0]        lock_q, lock_d;
    logic              locked_q, locked_d;

    mrzd_state_t       st_q, st_d;
    logic [4:0]        wait_q, wait_d;
    logic [BEAT_W-1:0] beat_q, beat_d;
    logic [BEAT_W-1:0] start_q, start_d;
    logic              is_wr_q, is_wr_d;
    logic              chop_q, chop_d;
    logic              oe_q, oe_d;
    logic              wen_q, wen_d;
    logic [BEAT_W-1:0] col_q, col_d;

    logic [1:0]        blen;
    logic [3:0]        lat_code;
    logic [3:0]        lat;
    logic [2:0]        wr_code;
    logic [4:0]        wrec;
    logic              cmd_chop;
    logic              is_mode0;
    logic [BEAT_W-1:0] col_w;

    assign blen     = mode_q[BLEN_LO +: 2];
    assign lat_code = {mode_q[LAT_LO +: 3], mode_q[LAT_EXT_BIT]};
    assign wr_code  = mode_q[WREC_LO +: 3];
    assign is_mode0 = (REQ.cmd == MRZD_CMD_MODE) && (REQ.bank == MODE0_BANK);

    always_comb
    begin
        // Latency code: bits 6:4 give four plus the field, bit 2 adds eight more
        case (lat_code)
            4'h2:    lat = 4'h5;
            4'h4:    lat = 4'h6;
            4'h6:    lat = 4'h7;
            4'h8:    lat = 4'h8;
            4'ha:    lat = 4'h9;
            4'hc:    lat = 4'ha;
            4'he:    lat = 4'hb;
            4'h1:    lat = 4'hc;
            4'h3:    lat = 4'hd;
            4'h5:    lat = 4'he;
            default: lat = 4'h5;
        endcase
        case (wr_code)
            3'h1:    wrec = 5'h05;
            3'h2:    wrec = 5'h06;
            3'h3:    wrec = 5'h07;
            3'h4:    wrec = 5'h08;
            3'h5:    wrec = 5'h0a;
            3'h6:    wrec = 5'h0c;
            3'h7:    wrec = 5'h0e;
            default: wrec = 5'h10;
        endcase
    end

    always_comb
    begin
        case (blen)
            BLEN_FIX4: cmd_chop = 1'b1;
            BLEN_OTF:  cmd_chop = ~REQ.addr[OTF_ADDR_BIT];
            default:   cmd_chop = 1'b0;
        endcase
    end

    // Mode load and DLL resync
    always_comb
    begin
        mode_d   = mode_q;
        rsvd_d   = rsvd_q;
        resync_d = 1'b0;
        lock_d   = lock_q;
        locked_d = locked_q;
        if (is_mode0)
        begin
            // Whole word replaces old settings; resync bit never stored
            mode_d = REQ.addr & ~(19'h1 << DLLRST_BIT);
            rsvd_d = |(REQ.addr & RSVD_MASK);
        end
        // A load without resync must not stall the lock count
        if (is_mode0 && REQ.addr[DLLRST_BIT])
        begin
            resync_d = 1'b1;
            lock_d   = 10'(LOCK_CYC);
            locked_d = 1'b0;
        end
        else if (lock_q != 10'h0)
        begin
            lock_d = lock_q - 10'h1;
            if (lock_q == 10'h1)
            begin
                locked_d = 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            mode_q   <= MODE_RST;
            rsvd_q   <= 1'b0;
            resync_q <= 1'b0;
            lock_q   <= 10'h0;
            locked_q <= 1'b0;
        end
        else
        begin
            mode_q   <= mode_d;
            rsvd_q   <= rsvd_d;
            resync_q <= resync_d;
            lock_q   <= lock_d;
            locked_q <= locked_d;
        end
    end

    // Burst sequencer: chop holds the full eight-slot window
    always_comb
    begin
        st_d    = st_q;
        wait_d  = wait_q;
        beat_d  = beat_q;
        start_d = start_q;
        is_wr_d = is_wr_q;
        chop_d  = chop_q;
        oe_d    = 1'b0;
        wen_d   = 1'b0;
        col_d   = col_q;
        case (st_q)
            MRZD_IDLE:
            begin
                if (REQ.cmd == MRZD_CMD_READ || REQ.cmd == MRZD_CMD_WRITE)
                begin
                    start_d = REQ.addr[BEAT_W-1:0];
                    is_wr_d = (REQ.cmd == MRZD_CMD_WRITE);
                    chop_d  = cmd_chop;
                    beat_d  = 3'h0;
                    // Edge n is this one; data on edge n+m
                    wait_d  = {1'b0, lat} - 5'h1;
                    st_d    = (lat == 4'h1) ? MRZD_BEATS : MRZD_WAIT;
                end
            end
            MRZD_WAIT:
            begin
                wait_d = wait_q - 5'h1;
                if (wait_q == 5'h1)
                begin
                    st_d = MRZD_BEATS;
                end
            end
            MRZD_BEATS:
            begin
                col_d  = col_w;
                // Last four slots of a chop stay high-Z
                oe_d   = ~is_wr_q & ~(chop_q & beat_q[2]);
                wen_d  = is_wr_q & ~(chop_q & beat_q[2]);
                beat_d = 3'(beat_q + 3'h1);
                if (beat_q == 3'(BEATS_FULL - 1))
                begin
                    st_d = MRZD_IDLE;
                end
            end
            default: st_d = MRZD_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            st_q    <= MRZD_IDLE;
            wait_q  <= 5'h0;
            beat_q  <= 3'h0;
            start_q <= 3'h0;
            is_wr_q <= 1'b0;
            chop_q  <= 1'b0;
            oe_q    <= 1'b0;
            wen_q   <= 1'b0;
            col_q   <= 3'h0;
        end
        else
        begin
            st_q    <= st_d;
            wait_q  <= wait_d;
            beat_q  <= beat_d;
            start_q <= start_d;
            is_wr_q <= is_wr_d;
            chop_q  <= chop_d;
            oe_q    <= oe_d;
            wen_q   <= wen_d;
            col_q   <= col_d;
        end
    end

    mrzd_beat_order u_order (
        .start_col  (start_q),
        .beat       (beat_q),
        .interleave (mode_q[BORD_BIT]),
        .is_write   (is_wr_q),
        .chop       (chop_q),
        .col        (col_w)
    );

    assign CFG.chop         = (blen == BLEN_FIX4);
    assign CFG.interleave   = mode_q[BORD_BIT];
    assign CFG.read_lat     = lat;
    assign CFG.write_rec    = wrec;
    assign CFG.pd_dll_on    = mode_q[PDDLL_BIT];
    assign CFG.reserved_err = rsvd_q;
    assign MODE_READBACK    = mode_q;
    assign DLL_RESYNC       = resync_q;
    assign DLL_LOCKED       = locked_q;
    // Active power-down ignores bit 12; DLL keeps running there
    assign DLL_RUN   = ~(PRECHARGE_PD & ~mode_q[PDDLL_BIT]);
    assign SLOW_EXIT = PRECHARGE_PD & ~ACTIVE_PD & ~mode_q[PDDLL_BIT];
    assign DATA_OE   = oe_q;
    assign STROBE_OE = oe_q;
    assign WRITE_EN  = wen_q;
    assign BEAT_COL  = col_q;
    assign BURST_BUSY = (st_q != MRZD_IDLE);

    a_dll_self_clear: assert property (@(posedge MCLK) disable iff (RST)
        DLL_RESYNC |-> !MODE_READBACK[DLLRST_BIT] ##1 !DLL_RESYNC)
        else $error("resync bit not self cleared");
    a_lock_wait: assert property (@(posedge MCLK) disable iff (RST)
        (is_mode0 && REQ.addr[DLLRST_BIT]) |=> !DLL_LOCKED [*8])
        else $error("locked too soon after resync");
    a_chop_tristate: assert property (@(posedge MCLK) disable iff (RST)
        (st_q == MRZD_BEATS && chop_q && beat_q[2]) |=> !DATA_OE)
        else $error("chop tail driven");
    a_full_drive: assert property (@(posedge MCLK) disable iff (RST)
        (st_q == MRZD_BEATS && !chop_q && !is_wr_q) |=> DATA_OE)
        else $error("full read beat not driven");
    a_write_order: assert property (@(posedge MCLK) disable iff (RST)
        (st_q == MRZD_BEATS && is_wr_q && !chop_q) |=> BEAT_COL == $past(beat_q))
        else $error("full write out of order");
    a_otf_select: assert property (@(posedge MCLK) disable iff (RST)
        (st_q == MRZD_IDLE && REQ.cmd == MRZD_CMD_READ && blen == BLEN_OTF)
        |=> chop_q == !$past(REQ.addr[OTF_ADDR_BIT]))
        else $error("on-the-fly length wrong");
    a_mode_hold: assert property (@(posedge MCLK) disable iff (RST)
        !is_mode0 |=> $stable(MODE_READBACK))
        else $error("settings changed without load");
    a_pd_dll: assert property (@(posedge MCLK) disable iff (RST)
        !PRECHARGE_PD |-> DLL_RUN)
        else $error("dll stopped outside precharge pd");
    a_read_latency: assert property (@(posedge MCLK) disable iff (RST)
        (st_q == MRZD_IDLE && REQ.cmd == MRZD_CMD_READ && lat == 4'h5)
        |=> !DATA_OE [*5] ##1 DATA_OE)
        else $error("first data not at n plus latency");

    c_chop_read: cover property (@(posedge MCLK) st_q == MRZD_BEATS && chop_q
        && !is_wr_q);
    c_full_write: cover property (@(posedge MCLK) WRITE_EN && !chop_q);
    c_resync: cover property (@(posedge MCLK) DLL_RESYNC);
    c_interleave: cover property (@(posedge MCLK) DATA_OE && CFG.interleave);

endmodule : mrzd_mode_zero
`default_nettype wire

// *** test/mrzd_ctrl_model.sv ***
// Controller model: issues mode loads and column commands
`timescale 1ns/1ps
`default_nettype none
module mrzd_ctrl_model
    import mrzd_pkg::*;
#(
    parameter int LOCK_WAIT = DLL_LOCK_CYC
)
(
    input  wire logic MCLK,
    output var  mrzd_req_t REQ
);
    logic lock_pend;

    initial
    begin
        REQ = '0;
        lock_pend = 1'b0;
    end

    // Recovery in cycles, any fraction rounded up
    function automatic logic [2:0] wrec_code(input int wr_ps, input int ck_ps);
        int cyc;
        cyc = (wr_ps + ck_ps - 1) / ck_ps;
        if (cyc <= 5)
            return 3'h1;
        else if (cyc <= 8)
            return 3'(cyc - 4);
        else if (cyc <= 14)
            return 3'((cyc + 1) / 2);
        else
            return 3'h0;
    endfunction : wrec_code

    // Callers wait out each burst before the next command
    task automatic issue(input mrzd_cmd_t cmd, input logic [BANK_W-1:0] bank,
                         input logic [MODE_W-1:0] addr, input logic rsvd);
        if (cmd == MRZD_CMD_READ && lock_pend)
        begin
            repeat (LOCK_WAIT) @(posedge MCLK);
            lock_pend = 1'b0;
        end
        @(posedge MCLK);
        #1;
        REQ.cmd = cmd;
        REQ.bank = bank;
        // Whole word each load, reserved bits zero unless told
        REQ.addr = (cmd == MRZD_CMD_MODE && !rsvd) ? addr & ~RSVD_MASK : addr;
        if (cmd == MRZD_CMD_MODE)
            lock_pend = lock_pend | addr[DLLRST_BIT];
        @(posedge MCLK);
        #1;
        REQ.cmd = MRZD_CMD_NONE;
        // Released lines must not keep showing the last value
        REQ.addr = ~REQ.addr;
        REQ.bank = ~REQ.bank;
    endtask : issue
endmodule : mrzd_ctrl_model
`default_nettype wire

// *** test/test_mrzd_mode_zero.sv ***
// Testbench for the mode register zero block
`timescale 1ns/1ps
`default_nettype none
module test_mrzd_mode_zero
    import mrzd_pkg::*;
;
    localparam int LOCK = 8;
    logic mclk, rst, pre_pd, act_pd, resync, locked, dll_run, slow_exit;
    logic data_oe, strobe_oe, write_en, busy;
    logic [BEAT_W-1:0] beat_col;
    logic [MODE_W-1:0] readback;
    mrzd_req_t req;
    mrzd_cfg_t cfg;
    int n_fail, checked;
    int wr_tab[8] = '{16, 5, 6, 7, 8, 10, 12, 14};

    mrzd_mode_zero #(.LOCK_CYC(LOCK)) uut (.MCLK(mclk), .RST(rst), .REQ(req),
        .PRECHARGE_PD(pre_pd), .ACTIVE_PD(act_pd), .CFG(cfg),
        .MODE_READBACK(readback), .DLL_RESYNC(resync), .DLL_LOCKED(locked),
        .DLL_RUN(dll_run), .SLOW_EXIT(slow_exit), .DATA_OE(data_oe),
        .STROBE_OE(strobe_oe), .WRITE_EN(write_en), .BEAT_COL(beat_col),
        .BURST_BUSY(busy));
    mrzd_ctrl_model #(.LOCK_WAIT(LOCK)) ctrl (.MCLK(mclk), .REQ(req));

    always #10 mclk = ~mclk;

    task automatic chkv(input logic [MODE_W-1:0] got,
                        input logic [MODE_W-1:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkv

    task automatic chk1(input logic got, input logic exp);
        chkv({18'h0, got}, {18'h0, exp});
    endtask : chk1

    function automatic logic [MODE_W-1:0] mw(input int cl, input logic [2:0] wrc,
        input logic il, input logic [1:0] bl, input logic pd);
        logic [MODE_W-1:0] w;
        w = '0;
        w[BLEN_LO +: 2] = bl;
        w[BORD_BIT] = il;
        w[PDDLL_BIT] = pd;
        w[WREC_LO +: 3] = wrc;
        w[LAT_LO +: 3] = (cl <= 11) ? 3'(cl - 4) : 3'(cl - 12);
        w[LAT_EXT_BIT] = (cl > 11);
        return w;
    endfunction : mw

    task automatic load(input logic [MODE_W-1:0] w, input logic rsvd);
        ctrl.issue(MRZD_CMD_MODE, MODE0_BANK, w, rsvd);
        chkv(readback, w & ~19'h00100);
        chk1(resync, w[DLLRST_BIT]);
    endtask : load

    task automatic t_decode;
        for (int i = 0; i < 10; i++)
        begin
            load(mw(5 + i, 3'(i % 8), i[0], BLEN_FIX8, 1'b0), 1'b0);
            chkv(19'(cfg.read_lat), 19'(5 + i));
            chkv(19'(cfg.write_rec), 19'(wr_tab[i % 8]));
            chk1(cfg.interleave, i[0]);
            chk1(cfg.reserved_err, 1'b0);
        end
        load(mw(5, ctrl.wrec_code(15000, 1600), 1'b0, BLEN_FIX8, 1'b0), 1'b0);
        chkv(19'(cfg.write_rec), 19'h0000a);
        load(mw(5, ctrl.wrec_code(15000, 1250), 1'b0, BLEN_FIX8, 1'b0), 1'b0);
        chkv(19'(cfg.write_rec), 19'h0000c);
        load(mw(7, 3'h2, 1'b0, BLEN_FIX4, 1'b0) | 19'h00080, 1'b1);
        chk1(cfg.reserved_err, 1'b1);
        chk1(cfg.chop, 1'b1);
        ctrl.issue(MRZD_CMD_MODE, 3'h1, 19'h00000, 1'b0);
        repeat (2) @(posedge mclk);
        #1;
        chkv(19'(cfg.read_lat), 19'h7);
        $display("test decode done");
    endtask : t_decode

    task automatic t_dll;
        load(mw(5, 3'h1, 1'b0, BLEN_FIX8, 1'b0) | 19'h00100, 1'b0);
        chk1(locked, 1'b0);
        @(posedge mclk);
        #1;
        chk1(resync, 1'b0);
        repeat (LOCK - 2) @(posedge mclk);
        #1;
        chk1(locked, 1'b0);
        @(posedge mclk);
        #1;
        chk1(locked, 1'b1);
        $display("test dll done");
    endtask : t_dll

    task automatic burst(input logic wr, input logic [1:0] bl,
        input logic [MODE_W-1:0] a, input logic il, input int cl);
        logic chop;
        logic [2:0] e;
        chop = (bl == BLEN_FIX4) || (bl == BLEN_OTF && !a[OTF_ADDR_BIT]);
        ctrl.issue(wr ? MRZD_CMD_WRITE : MRZD_CMD_READ, 3'h0, a, 1'b0);
        repeat (cl - 1) @(posedge mclk);
        #1;
        chk1(wr ? write_en : data_oe, 1'b0);
        chk1(busy, 1'b1);
        for (int b = 0; b < 8; b++)
        begin
            @(posedge mclk);
            #1;
            if (wr)
                e = chop ? {a[2], b[1:0]} : b[2:0];
            else if (il)
                e = a[2:0] ^ b[2:0];
            else
                e = {a[2] ^ b[2], a[1:0] + b[1:0]};
            chk1(wr ? write_en : data_oe, !chop || b < 4);
            if (!wr)
                chk1(strobe_oe, !chop || b < 4);
            if (!chop || b < 4)
                chkv(19'(beat_col), 19'(e));
        end
        @(posedge mclk);
        #1;
        chk1(busy, 1'b0);
    endtask : burst

    task automatic t_bursts;
        for (int k = 0; k < 4; k++)
        begin
            load(mw(5 + 2 * k, 3'h1, k[0], BLEN_FIX8, 1'b0), 1'b0);
            for (int s = 0; s < 8; s++)
                burst(1'b0, BLEN_FIX8, 19'(s), k[0], 5 + 2 * k);
        end
        load(mw(6, 3'h1, 1'b1, BLEN_FIX4, 1'b0), 1'b0);
        for (int s = 0; s < 8; s++)
        begin
            burst(1'b0, BLEN_FIX4, 19'(s), 1'b1, 6);
            burst(1'b1, BLEN_FIX4, 19'(s) | 19'h3, 1'b1, 6);
        end
        load(mw(12, 3'h1, 1'b0, BLEN_OTF, 1'b0), 1'b0);
        for (int j = 0; j < 4; j++)
            burst(j[1], BLEN_OTF, (19'(j[0]) << 12) | 19'h5, 1'b0, 12);
        burst(1'b1, BLEN_OTF, 19'h01007, 1'b0, 12);
        $display("test bursts done");
    endtask : t_bursts

    task automatic t_pd;
        for (int i = 0; i < 6; i++)
        begin
            load(mw(5, 3'h1, 1'b0, BLEN_FIX8, i[0]), 1'b0);
            pre_pd = i[1];
            act_pd = i[2];
            @(posedge mclk);
            #1;
            chk1(dll_run, !(i[1] && !i[0]));
            chk1(slow_exit, i[1] && !i[2] && !i[0]);
            chk1(cfg.pd_dll_on, i[0]);
        end
        pre_pd = 1'b0;
        act_pd = 1'b0;
        $display("test power-down done");
    endtask : t_pd

    task automatic results;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    initial
    begin
        mclk = 1'b0;
        rst = 1'b1;
        pre_pd = 1'b0;
        act_pd = 1'b0;
        n_fail = 0;
        checked = 0;
        repeat (3) @(posedge mclk);
        #1;
        chkv(readback, 19'h0);
        chkv(19'(cfg.read_lat), 19'h5);
        chkv(19'(cfg.write_rec), 19'h10);
        repeat (3) @(posedge mclk);
        #1;
        rst = 1'b0;
        $display("test reset done");
        t_decode;
        t_dll;
        t_bursts;
        t_pd;
        results;
    end

    // Whole run needs about a thousand cycles
    initial
    begin
        #400000;
        n_fail++;
        results;
    end
endmodule : test_mrzd_mode_zero
`default_nettype wire
